// >>> verification/npc_host.sv
`timescale 1ns/1ps
`default_nettype none
module npc_host(input wire logic clk_sys,output logic state_wr,output logic [1:0] state_wdata);
  initial {state_wr,state_wdata}=3'h0;
  task put(logic [1:0] s);
    state_wr=1;
    state_wdata=s;
    @(posedge clk_sys);
    #1;
    state_wr=0;
    state_wdata=~s;
    @(posedge clk_sys);
    #1;
  endtask : put
endmodule : npc_host
`default_nettype wire

// >>> verification/npc_power_ctl_props.sv
`timescale 1ns/1ps
`default_nettype none
module npc_props(input wire logic clk_sys,sys_rst,state_wr,sys_wake,host_tx_req,host_tx_ack,
  context_lost,pme_out,input wire logic [1:0] state_wdata,power_state);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire d0=power_state==0;
  chk_tx_low: assert property(!d0|->!host_tx_ack)else $error("tx");
  chk_tx_full: assert property(d0|->host_tx_ack==host_tx_req)else $error("tx");
  chk_wake_d0: assert property(sys_wake|=>d0)else $error("wake");
  chk_wake_clr: assert property(sys_wake|=>!pme_out)else $error("wake");
  chk_wr_state: assert property(state_wr&&!sys_wake|=>power_state==$past(state_wdata))else $error("wr");
  chk_state_hold: assert property(!state_wr&&!sys_wake|=>$stable(power_state))else $error("hold");
  chk_ctx_set: assert property(!d0|->context_lost)else $error("ctx");
  chk_pme_low: assert property($rose(pme_out)|->!$past(d0))else $error("pme");
  cover property(power_state==3);
  cover property($rose(pme_out));
  cover property(sys_wake&&!d0);
endmodule : npc_props
bind npc_power_ctl npc_props u_props(.*);
`default_nettype wire

// >>> verification/npc_power_ctl_test.sv
`timescale 1ns/1ps
`default_nettype none
module npc_power_ctl_test;
  logic clk_sys=0,sys_rst=1,sys_wake=0,link_wake_en=1,link_up=0,rx_frame_valid=0,host_tx_req=0;
  logic rx_dma_req=0,dev_irq=0,state_wr,host_tx_ack,rx_dma_grant,host_irq,context_lost,link_stable,pme_out;
  logic [1:0] state_wdata,power_state;
  logic [7:0] rx_frame_key=8'h4A;
  int n_errors=0,tests_run=0,cyc=0;
  npc_host HOST(.*);
  npc_power_ctl DUT(.*,.wake_en(1'b1),.frame_wake_en(1'b1),.wake_pattern(8'h5A),.wake_mask(8'hF0));
  initial forever #5 clk_sys=~clk_sys;
  always @(posedge clk_sys) if (++cyc>3000) begin n_errors++; give_verdict; end
  task cmp(logic [7:0] g,e);
    tests_run++;
    if (g!==e) begin n_errors++; $display("CHECK FAILED %0t got %h",$time,g); end
  endtask : cmp
  task give_verdict;
    $display("errors %0d of %0d",n_errors,tests_run);
    if (n_errors==0&&tests_run>0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task wt(int n); repeat (n) @(posedge clk_sys); #1; endtask : wt
  task t_gate;
    for (int s=0;s<4;s++) begin
      HOST.put(s[1:0]);
      {host_tx_req,rx_dma_req,dev_irq}=3'h7;
      #1 cmp({host_tx_ack,rx_dma_grant,host_irq,context_lost},{{3{s==0}},s!=0});
    end
  endtask : t_gate
  task t_wake;
    link_up=1;
    wt(999);
    link_up=0;
    rx_frame_valid=1;
    wt(1);
    cmp({link_stable,pme_out},0);
    rx_frame_key=8'h53;
    wt(1);
    cmp(pme_out,1);
    sys_wake=1;
    wt(1);
    cmp({power_state,pme_out},0);
  endtask : t_wake
  task t_link;
    sys_wake=0;
    rx_frame_valid=0;
    HOST.put(2'h1);
    link_up=1;
    wt(999);
    cmp({link_stable,pme_out},0);
    wt(1);
    cmp({link_stable,pme_out},8'h03);
    sys_rst=1;
    wt(2);
    sys_rst=0;
    cmp({power_state,context_lost,link_stable,pme_out},0);
  endtask : t_link
  initial begin
    wt(2);
    sys_rst=0;
    t_gate;
    t_wake;
    t_link;
    give_verdict;
  end
endmodule : npc_power_ctl_test
`default_nettype wire

// >>> verilog/npc_pkg.sv
package npc_pkg;

  // Power state encoding held in the two-bit state field.
  typedef enum logic [1:0] {
    NPC_D0 = 2'h0,
    NPC_D1 = 2'h1,
    NPC_D2 = 2'h2,
    NPC_D3 = 2'h3
  } npc_pstate_t;

  localparam logic NPC_HAS_D1 = 1'b1;
  localparam logic NPC_HAS_D2 = 1'b1;

  // Link debounce time in microseconds and its cycle count at 100 MHz.
  localparam int NPC_CLK_MHZ = 100;
  localparam int NPC_LINK_DEB_US = 10;
  localparam int NPC_LINK_DEB_CYC = NPC_LINK_DEB_US * NPC_CLK_MHZ;
  localparam int NPC_DEB_W = 11;

  localparam int NPC_PAT_W = 8;

endpackage : npc_pkg

// >>> verilog/npc_power_ctl.sv
`timescale 1ns/1ps
`default_nettype none

// Contract
// RULE_01: In full power the device passes transmit, receive and interrupts through unchanged.
// RULE_02: In any low-power state transmit requests from the host are refused.
// RULE_03: In any low-power state received data is not moved into host memory.
// RULE_04: In any low-power state no interrupt reaches the host.
// RULE_05: Context may be lost in the intermediate states and is treated as lost in the deepest state.
// RULE_06: On sleep with wake enabled the host selects the lowest state that can still signal wake.
// RULE_07: After link loss and a timeout the host selects the lowest state that still detects link up.
// RULE_08: On shutdown or sleep without wake the host moves the device straight to the deepest state.
// RULE_09: On system wake the device is returned from any low-power state to full power.
// RULE_10: Wake events come from a link-status change or from a recognised wake frame.
// RULE_11: Link-status changes are debounced so brief toggles raise no wake.
// RULE_12: Full power and the deepest state exist; the intermediate states are optional.
// RULE_13: Wake frames are recognised only by the host-programmed match criteria.
// RULE_14: The state is a two-bit field written by the host; a request for an absent state is ignored.
module npc_power_ctl
  import npc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic state_wr,
  input wire logic [1:0] state_wdata,
  input wire logic sys_wake,
  input wire logic wake_en,
  input wire logic link_wake_en,
  input wire logic frame_wake_en,
  input wire logic [NPC_PAT_W-1:0] wake_pattern,
  input wire logic [NPC_PAT_W-1:0] wake_mask,
  input wire logic link_up,
  input wire logic rx_frame_valid,
  input wire logic [NPC_PAT_W-1:0] rx_frame_key,
  input wire logic host_tx_req,
  output logic host_tx_ack,
  input wire logic rx_dma_req,
  output logic rx_dma_grant,
  input wire logic dev_irq,
  output logic host_irq,
  output logic [1:0] power_state,
  output logic context_lost,
  output logic link_stable,
  output logic pme_out
);

  typedef struct packed {
    npc_pstate_t state;
    logic ctx_lost;
    logic link_db;
    logic [NPC_DEB_W-1:0] deb_cnt;
    logic pme;
  } npc_state_t;

  npc_state_t s_reg;
  npc_state_t s_next;
  logic low_pwr;
  logic req_ok;
  logic frame_hit;

  assign low_pwr = (s_reg.state != NPC_D0);
  assign host_tx_ack = host_tx_req & ~low_pwr; // RULE_01 RULE_02
  assign rx_dma_grant = rx_dma_req & ~low_pwr; // RULE_03
  assign host_irq = dev_irq & ~low_pwr; // RULE_04
  assign power_state = s_reg.state;
  assign context_lost = s_reg.ctx_lost;
  assign link_stable = s_reg.link_db;
  assign pme_out = s_reg.pme;

  always_comb begin
    unique case (npc_pstate_t'(state_wdata))
      NPC_D1: req_ok = NPC_HAS_D1; // RULE_12 RULE_14
      NPC_D2: req_ok = NPC_HAS_D2; // RULE_12 RULE_14
      default: req_ok = 1'b1;
    endcase
  end

  // Only the bits the host selects in the mask take part in the match.
  assign frame_hit = rx_frame_valid & (((rx_frame_key ^ wake_pattern) & wake_mask) == '0); // RULE_13

  always_comb begin
    s_next = s_reg;
    // A new link level must hold for the whole debounce time before it counts.
    if (link_up == s_reg.link_db) begin
      s_next.deb_cnt = '0;
    end else if (s_reg.deb_cnt == NPC_DEB_W'(NPC_LINK_DEB_CYC - 1)) begin // RULE_11
      s_next.deb_cnt = '0;
      s_next.link_db = link_up;
      if (low_pwr && wake_en && link_wake_en) begin
        s_next.pme = 1'b1; // RULE_10
      end
    end else begin
      s_next.deb_cnt = s_reg.deb_cnt + NPC_DEB_W'(1);
    end
    if (low_pwr && wake_en && frame_wake_en && frame_hit) begin
      s_next.pme = 1'b1; // RULE_10 RULE_13
    end
    if (state_wr && req_ok) begin // RULE_14 RULE_06 RULE_07 RULE_08
      s_next.state = npc_pstate_t'(state_wdata);
      if (npc_pstate_t'(state_wdata) != NPC_D0) begin
        s_next.ctx_lost = 1'b1; // RULE_05
      end
    end
    if (sys_wake) begin
      s_next.state = NPC_D0; // RULE_09
      s_next.pme = 1'b0;
    end
    if (s_next.state == NPC_D0 && low_pwr) begin
      s_next.pme = 1'b0;
    end
    if (state_wr && !low_pwr && npc_pstate_t'(state_wdata) == NPC_D0) begin
      s_next.ctx_lost = 1'b0; // RULE_05
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_reg <= '{state: NPC_D0, ctx_lost: 1'b0, link_db: 1'b0, deb_cnt: '0, pme: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

endmodule : npc_power_ctl

`default_nettype wire
